// ==== hdl/tuning_defs.vh ====
// Constants for the voltage-synthesis tuning output block.
// Assumes the core clock rate below; all counts are derived from these in the modules.
`ifndef TUNING_DEFS_VH
`define TUNING_DEFS_VH

// Tuning word layout
`define TVS_WORD_W      14
`define TVS_HALF_W      7
`define TVS_COARSE_MSB  13
`define TVS_COARSE_LSB  7
`define TVS_FINE_MSB    6
`define TVS_FINE_LSB    0

// Reset values
`define TVS_WORD_RST    14'h0000
`define TVS_HALF_RST    7'h00
`define TVS_CNT_LAST    14'h3FFF

// Clock rates in Hz
`define TVS_CORE_CLK_HZ 40000000
`define TVS_SYS_4M_HZ   4000000
`define TVS_SYS_8M_HZ   8000000
`define TVS_REF_HZ      2000000

`endif

// ==== hdl/ref_step_div.v ====
// Two-stage divider: core clock to system-clock ticks, then system ticks to reference steps.
// Assumes core_clk is a whole multiple of both stage rates; ce freezes all state.
`timescale 1ns/1ps

module ref_step_div #(
  parameter SYS_DIV = 10,
  parameter REF_DIV = 2
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rstn,
  input  wire       ce,
  // Tick outputs
  output wire       sys_tick,
  output wire       ref_tick
);

  localparam [7:0] SYS_LAST = SYS_DIV[7:0] - 8'h01;
  localparam [7:0] REF_LAST = REF_DIV[7:0] - 8'h01;

  reg [7:0] sys_cnt_q;
  reg [7:0] ref_cnt_q;
  reg       sys_tick_q;
  reg       ref_tick_q;

  assign sys_tick = sys_tick_q;
  assign ref_tick = ref_tick_q;

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sys_cnt_q  <= 8'h00;
      ref_cnt_q  <= 8'h00;
      sys_tick_q <= 1'b0;
      ref_tick_q <= 1'b0;
    end
    else if (ce)
    begin
      sys_tick_q <= 1'b0;
      ref_tick_q <= 1'b0;
      if (sys_cnt_q == SYS_LAST)
      begin
        sys_cnt_q  <= 8'h00;
        sys_tick_q <= 1'b1;
        // Reference step is the system clock divided by two or by four
        if (ref_cnt_q == REF_LAST)
        begin
          ref_cnt_q  <= 8'h00;
          ref_tick_q <= 1'b1;
        end
        else
        begin
          ref_cnt_q <= ref_cnt_q + 8'h01;
        end
      end
      else
      begin
        sys_cnt_q <= sys_cnt_q + 8'h01;
      end
    end
  end

endmodule // ref_step_div

// ==== hdl/tuning_voltage_pwm_brm.v ====
// Voltage-synthesis tuning output: 14-bit word to one PWM/BRM pulse train.
// Assumes an external low-pass filter on the output and a host that writes the coarse half before the fine half.
`timescale 1ns/1ps
`include "tuning_defs.vh"

// Notes on behaviour
// - One 14-bit tuning word, written as two halves, sets the whole output.
// - One output period spans 16384 reference steps; each word count adds one high step.
// - The seven upper word bits set the coarse pulse width in each subperiod.
// - The seven lower word bits spread extra single high steps by bit-rate multiplication.
// - An all-zero word keeps the output low for the whole period.
// - Small words give a growing count of equal pulses, up to 128 per period.
// - Above 128 the pulse count stays 128 and the pulses widen.
// - Near full scale adjacent pulses merge, so the separate pulse count falls.
// - An all-ones word leaves exactly one low step per period.
// - Reference steps run at 2 MHz, the 4 MHz system clock divided by two.
// - A build option takes the same 2 MHz from an 8 MHz system clock, divided by four.
module tuning_voltage_pwm_brm #(
  parameter OPT_8MHZ = 0,
  parameter WORD_W   = `TVS_WORD_W
) (
  // Clock, reset and clock enable
  input  wire                  core_clk,
  input  wire                  rstn,
  input  wire                  ce,
  // Tuning word writes
  input  wire                  coarse_wr,
  input  wire [WORD_W/2-1:0]   coarse_data,
  input  wire                  fine_wr,
  input  wire [WORD_W/2-1:0]   fine_data,
  // Readback and status
  output wire [WORD_W/2-1:0]   coarse_rd,
  output wire [WORD_W/2-1:0]   fine_rd,
  output wire [WORD_W-1:0]     word_active,
  output wire                  update_pending,
  output wire                  period_start,
  // Tuning pin
  output wire                  tuning_voltage_output
);

  localparam HALF_W   = WORD_W / 2;
  localparam SYS_HZ   = OPT_8MHZ ? `TVS_SYS_8M_HZ : `TVS_SYS_4M_HZ;
  localparam SYS_DIV  = `TVS_CORE_CLK_HZ / SYS_HZ;
  localparam REF_DIV  = SYS_HZ / `TVS_REF_HZ;
  localparam [WORD_W-1:0] CNT_LAST = {WORD_W{1'b1}};

  // Coarse half is held until the fine half arrives, so a half-written word is never staged
  reg [HALF_W-1:0] coarse_hold_q;
  reg [WORD_W-1:0] staged_q;
  reg              pending_q;
  reg [WORD_W-1:0] active_q;
  reg [WORD_W-1:0] pos_q;
  reg              out_q;
  reg              period_start_q;

  reg [WORD_W-1:0] staged_d;
  reg              pending_d;
  reg              take_new;
  reg              out_d;

  wire             ref_tick;
  wire             wrap_step;

  assign coarse_rd             = coarse_hold_q;
  assign fine_rd               = staged_q[HALF_W-1:0];
  assign word_active           = active_q;
  assign update_pending        = pending_q;
  assign period_start          = period_start_q;
  assign tuning_voltage_output = out_q;

  // Next step position; shared by the counter and the look-ahead level
  function [WORD_W-1:0] next_pos;
    input [WORD_W-1:0] pos;
    begin
      next_pos = pos + {{(WORD_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Last step of the period, where the counter wraps
  function last_step;
    input [WORD_W-1:0] pos;
    begin
      last_step = (pos == CNT_LAST);
    end
  endfunction

  // Subperiod index with its bits in reverse order
  function [HALF_W-1:0] bit_rev;
    input [HALF_W-1:0] idx;
    integer            i;
    begin
      for (i = 0; i < HALF_W; i = i + 1)
      begin
        bit_rev[i] = idx[HALF_W-1-i];
      end
    end
  endfunction

  // Level of the output at one step of the period for a given word
  function step_high;
    input [WORD_W-1:0] pos;
    input [WORD_W-1:0] word;
    reg   [HALF_W-1:0] sub;
    reg   [HALF_W-1:0] idx;
    reg   [HALF_W-1:0] rev;
    reg   [HALF_W-1:0] coarse;
    reg   [HALF_W-1:0] fine;
    begin
      sub    = pos[HALF_W-1:0];
      idx    = pos[WORD_W-1:HALF_W];
      coarse = word[WORD_W-1:HALF_W];
      fine   = word[HALF_W-1:0];
      // Bit-reversed subperiod index spreads the extras evenly over the period
      rev    = bit_rev(idx);
      // Coarse steps high, then one extra step in 'fine' of the subperiods
      step_high = (sub < coarse) | ((sub == coarse) & (rev < fine));
    end
  endfunction

  ref_step_div #(
    .SYS_DIV (SYS_DIV),
    .REF_DIV (REF_DIV)
  ) u_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .sys_tick (),
    .ref_tick (ref_tick)
  );

  // Counter wrap on a reference step; a staged word can only be taken here
  assign wrap_step = ref_tick & last_step(pos_q);

  // Staging and hand-over of the tuning word
  always @*
  begin
    take_new = wrap_step & pending_q;
    staged_d = staged_q;
    if (fine_wr)
    begin
      staged_d = {(coarse_wr ? coarse_data : coarse_hold_q), fine_data};
    end
    // A fine write in the hand-over cycle stays pending for the next period
    if (fine_wr)
    begin
      pending_d = 1'b1;
    end
    else if (take_new)
    begin
      pending_d = 1'b0;
    end
    else
    begin
      pending_d = pending_q;
    end
  end

  // Output level for the step that follows
  always @*
  begin
    if (wrap_step)
    begin
      out_d = step_high({WORD_W{1'b0}}, take_new ? staged_q : active_q);
    end
    else
    begin
      out_d = step_high(next_pos(pos_q), active_q);
    end
  end

  // Write side: coarse hold, staged word and pending flag
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      coarse_hold_q <= `TVS_HALF_RST;
      staged_q      <= `TVS_WORD_RST;
      pending_q     <= 1'b0;
    end
    else if (ce)
    begin
      if (coarse_wr)
      begin
        coarse_hold_q <= coarse_data;
      end
      staged_q  <= staged_d;
      pending_q <= pending_d;
    end
  end

  // Period side: step position, active word and output level
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      active_q       <= `TVS_WORD_RST;
      pos_q          <= CNT_LAST;
      out_q          <= 1'b0;
      period_start_q <= 1'b0;
    end
    else if (ce)
    begin
      period_start_q <= 1'b0;
      if (ref_tick)
      begin
        // An all-zero word never raises the output; all ones leaves one low step
        out_q <= out_d;
        if (last_step(pos_q))
        begin
          pos_q          <= {WORD_W{1'b0}};
          period_start_q <= 1'b1;
          if (take_new)
          begin
            active_q <= staged_q;
          end
        end
        else
        begin
          pos_q <= next_pos(pos_q);
        end
      end
    end
  end

endmodule // tuning_voltage_pwm_brm

// ==== verif/tuner_filter.sv ====
// Tuner low-pass filter stand-in.
// Assumes the pin is sampled on the core clock.
`timescale 1ns/1ps
module tuner_filter (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Pin and level
  input  wire        tuning_voltage_output,
  output reg  [15:0] level_q
);
  // Crude integrator: counts cycles high, so ripple never hides a lost step
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      level_q <= 16'h0000;
    else if (tuning_voltage_output)
      level_q <= level_q + 16'h0001;
  end
endmodule // tuner_filter

// ==== verif/tvs_chk_asserts.sv ====
// Checker for the tuning output block.
// Assumes one core clock domain.
`timescale 1ns/1ps
module tvs_chk #(parameter WORD_W = 14) (
  // Clock and writes
  input wire                core_clk,
  input wire                rstn,
  input wire                ce,
  input wire                coarse_wr,
  input wire [WORD_W/2-1:0] coarse_data,
  input wire                fine_wr,
  input wire [WORD_W/2-1:0] fine_data,
  // Status and pin
  input wire [WORD_W/2-1:0] coarse_rd,
  input wire [WORD_W/2-1:0] fine_rd,
  input wire [WORD_W-1:0]   word_active,
  input wire                update_pending,
  input wire                period_start,
  input wire                tuning_voltage_output
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  coarse_hold_a:
    assert property (ce && coarse_wr |=> coarse_rd == $past(coarse_data)) else $error("bad coarse");
  fine_stage_a:
    assert property (ce && fine_wr |=> fine_rd == $past(fine_data) && update_pending) else $error("bad stage");
  take_clear_a:
    assert property ($rose(period_start) && !$past(fine_wr) |-> !update_pending) else $error("bad pending");
  word_hold_a:
    assert property (!period_start |-> $stable(word_active)) else $error("word moved");
  start_gap_a:
    assert property (period_start && ce |=> !period_start [*8]) else $error("bad period");
  zero_low_a:
    assert property (word_active == 14'h0000 && !period_start |-> !tuning_voltage_output) else $error("zero high");
  step_hold_a:
    assert property ($changed(tuning_voltage_output) |=> $stable(tuning_voltage_output) [*8]) else $error("short step");
  fine_take_a:
    assert property ($rose(period_start) && $past(update_pending) |->
                     word_active[WORD_W/2-1:0] == $past(fine_rd)) else $error("bad take");
endmodule // tvs_chk
bind tuning_voltage_pwm_brm tvs_chk #(.WORD_W(WORD_W)) chk (
  .core_clk              (core_clk),
  .rstn                  (rstn),
  .ce                    (ce),
  .coarse_wr             (coarse_wr),
  .coarse_data           (coarse_data),
  .fine_wr               (fine_wr),
  .fine_data             (fine_data),
  .coarse_rd             (coarse_rd),
  .fine_rd               (fine_rd),
  .word_active           (word_active),
  .update_pending        (update_pending),
  .period_start          (period_start),
  .tuning_voltage_output (tuning_voltage_output)
);

// ==== verif/tuning_voltage_pwm_brm_test.sv ====
// Self-checking bench for the tuning output block.
// Assumes the 4 MHz option; each row starts from reset.
`timescale 1ns/1ps
module tuning_voltage_pwm_brm_test;
  reg         core_clk = 1'b0, rstn = 1'b0, ce = 1'b1, coarse_wr = 1'b0, fine_wr = 1'b0;
  reg  [6:0]  coarse_data = 7'h00, fine_data = 7'h00;
  wire [6:0]  coarse_rd, fine_rd;
  wire [13:0] word_active;
  wire        update_pending, period_start, pin;
  wire [15:0] level_q;
  integer     fail_count = 0, comparisons = 0, i, k, n;
  reg  [29:0] rows [0:5];
  always #12.5 core_clk = ~core_clk;
  tuning_voltage_pwm_brm dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .coarse_wr(coarse_wr),
    .coarse_data(coarse_data), .fine_wr(fine_wr), .fine_data(fine_data), .coarse_rd(coarse_rd),
    .fine_rd(fine_rd), .word_active(word_active), .update_pending(update_pending),
    .period_start(period_start), .tuning_voltage_output(pin));
  tuner_filter filt (.core_clk(core_clk), .rstn(rstn), .tuning_voltage_output(pin), .level_q(level_q));
  task check(input string what, input [15:0] seen, input [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected %0s: expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // Level of step p: coarse width, plus one extra where reversed index is below fine
  function lvl(input [13:0] w, input [13:0] p);
    reg [6:0] r;
    integer b;
  begin
    for (b = 0; b < 7; b = b + 1)
      r[b] = p[13-b];
    lvl = p[6:0] < w[13:7] || (p[6:0] == w[13:7] && r < w[6:0]);
  end
  endfunction
  task test_done;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // Steps k sampled 1 ns after every 20th edge from the period start
  task steps(input [13:0] w, input integer a, input integer b);
  begin
    for (k = a; k < b; k = k + 1)
    begin
      check("level", pin, lvl(w, k));
      repeat (20) @(posedge core_clk);
      #1;
    end
  end
  endtask
  initial
  begin
    repeat (50000) @(posedge core_clk);
    fail_count = fail_count + 1;
    test_done;
  end
  initial
  begin
    rows[0] = {14'h0000, 16'h0000};
    rows[1] = {14'h0001, 16'h0001};
    rows[2] = {14'h0041, 16'h0002};
    rows[3] = {14'h0080, 16'h0002};
    rows[4] = {14'h3FFF, 16'h0100};
    rows[5] = {14'h1A55, 16'h006A};
    for (i = 0; i < 6; i = i + 1)
    begin
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (5) @(posedge core_clk);
      check("reset pin", pin, 16'h0000);
      check("reset word", word_active, 16'h0000);
      check("reset pending", update_pending, 16'h0000);
      rstn <= 1'b1;
      @(posedge core_clk);
      coarse_wr <= 1'b1;
      fine_wr <= 1'b1;
      {coarse_data, fine_data} <= rows[i][29:16];
      @(posedge core_clk);
      coarse_wr <= 1'b0;
      fine_wr <= 1'b0;
      n = 0;
      while (period_start !== 1'b1 && n < 40)
      begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      check("period start", period_start, 16'h0001);
      check("word", word_active, rows[i][29:16]);
      steps(rows[i][29:16], 0, 256);
      check("filter", level_q, rows[i][15:0] * 16'h0014);
      $display("row %0d done", i);
    end
    // Mid-period write must wait for the next period
    @(posedge core_clk);
    coarse_wr <= 1'b1;
    coarse_data <= 7'h7F;
    @(posedge core_clk);
    coarse_wr <= 1'b0;
    fine_wr <= 1'b1;
    fine_data <= 7'h7F;
    @(posedge core_clk);
    fine_wr <= 1'b0;
    repeat (17) @(posedge core_clk);
    #1;
    check("pending", update_pending, 16'h0001);
    check("held word", word_active, rows[5][29:16]);
    check("coarse readback", coarse_rd, 16'h007F);
    check("fine readback", fine_rd, 16'h007F);
    steps(rows[5][29:16], 257, 300);
    $display("hold test done");
    // Clock enable low for 30 cycles: every later step arrives 30 cycles late
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (30) @(posedge core_clk);
    ce <= 1'b1;
    repeat (19) @(posedge core_clk);
    #1;
    steps(rows[5][29:16], 301, 310);
    $display("freeze test done");
    test_done;
  end
endmodule // tuning_voltage_pwm_brm_test
